// [dacc_pkg.sv]
// constants and types shared by the dual capture/compare arrays
package dacc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned DACC_W = 16;
  localparam int unsigned DACC_ARRAYS = 2;
  localparam int unsigned DACC_REGS_PER_ARRAY = 16;
  localparam int unsigned DACC_CH = DACC_ARRAYS * DACC_REGS_PER_ARRAY;
  localparam int unsigned DACC_TIMERS = 4;
  localparam int unsigned DACC_CH_IDX_W = 5;
  localparam int unsigned DACC_TMR_IDX_W = 2;
  localparam int unsigned DACC_SECOND_PIN_REGS = 12;
  localparam int unsigned DACC_DBL_PAIR_OFS = 8;

  // ----------------------------------------------------------------
  // timing: prescaler base periods in system clock cycles
  // ----------------------------------------------------------------
  localparam int unsigned DACC_NORMAL_RES_CYC = 1;
  localparam int unsigned DACC_STAGGER_RES_CYC = 8;
  localparam logic [2:0] DACC_STAGGER_SHIFT = 3'h3;
  localparam int unsigned DACC_PRESC_W = 7;

  // ----------------------------------------------------------------
  // timer count source select
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DACC_SRC_DIV1 = 3'b000,
    DACC_SRC_DIV2 = 3'b001,
    DACC_SRC_DIV4 = 3'b010,
    DACC_SRC_DIV8 = 3'b011,
    DACC_SRC_EXT_OVF = 3'b100,
    DACC_SRC_EXT_CNT = 3'b101,
    DACC_SRC_STOP6 = 3'b110,
    DACC_SRC_STOP7 = 3'b111
  } dacc_src_t;

  // ----------------------------------------------------------------
  // channel function: bit 2 set means compare, low bits the mode
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DACC_FN_OFF = 3'b000,
    DACC_FN_CAPTURE = 3'b001,
    DACC_FN_RSV2 = 3'b010,
    DACC_FN_RSV3 = 3'b011,
    DACC_FN_CMP0 = 3'b100,
    DACC_FN_CMP1 = 3'b101,
    DACC_FN_CMP2 = 3'b110,
    DACC_FN_CMP3 = 3'b111
  } dacc_fn_t;

  // capture edge select bits
  localparam int unsigned DACC_EDGE_RISE_BIT = 0;
  localparam int unsigned DACC_EDGE_FALL_BIT = 1;

  // reset values
  localparam logic [15:0] DACC_RST_VAL = 16'h0000;
  localparam logic [6:0] DACC_PRESC_RST = 7'h00;

endpackage : dacc_pkg

// [dacc_timer.sv]
// one reloadable up-counting time base
module dacc_timer #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic step_en,
  input wire logic wr_count,
  input wire logic wr_reload,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] value_q,
  output logic step_q,
  output logic ovf_q
);
  import dacc_pkg::*;

  logic [WIDTH-1:0] reload_q;
  logic [WIDTH-1:0] value_d;
  wire at_top = &value_q;
  wire wrap = step_en & at_top;

  if (WIDTH < 2) begin : g_chk
    $error("dacc_timer: WIDTH must be at least 2");
  end

  // software write of the count wins over a step in the same cycle
  assign value_d = wr_count ? wdata :
                   wrap ? reload_q :
                   step_en ? value_q + 1'b1 : value_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      value_q <= '0;
      reload_q <= '0;
      step_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      value_q <= value_d;
      if (wr_reload) begin
        reload_q <= wdata;
      end
      step_q <= step_en & ~wr_count;
      ovf_q <= wrap & ~wr_count;
    end
  end

endmodule // dacc_timer

// [dacc_top.sv]
// two capture/compare arrays with four reloadable time bases

module dacc_top #(
  parameter int unsigned SECOND_PIN_REGS = dacc_pkg::DACC_SECOND_PIN_REGS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic staggered_mode,
  input wire logic ext_overflow_pulse,
  input wire logic [1:0] ext_count_in,
  input wire logic [11:0] tmr_src,
  input wire logic [3:0] tmr_run,
  input wire logic [dacc_pkg::DACC_TMR_IDX_W-1:0] tmr_wr_sel,
  input wire logic tmr_wr_count,
  input wire logic tmr_wr_reload,
  input wire logic [15:0] tmr_wdata,
  input wire logic [95:0] cc_func,
  input wire logic [31:0] cc_timer_b_sel,
  input wire logic [63:0] cc_edge_sel,
  input wire logic [31:0] cc_single_event,
  input wire logic [31:0] cc_double_reg,
  input wire logic reg_wr,
  input wire logic [dacc_pkg::DACC_CH_IDX_W-1:0] reg_sel,
  input wire logic [15:0] reg_wdata,
  input wire logic [31:0] cc_pin_in,
  output logic [31:0] cc_pin_out_q,
  output logic [31:0] cc_pin_oe_b_q,
  output logic [31:0] cc_irq_q,
  output logic [15:0] reg_rdata_q,
  output logic [63:0] tmr_value_q,
  output logic [31:0] cc_single_done_q
);
  import dacc_pkg::*;

  if (SECOND_PIN_REGS > DACC_REGS_PER_ARRAY) begin : g_chk
    $error("dacc_top: SECOND_PIN_REGS cannot exceed 16");
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  logic [DACC_PRESC_W-1:0] presc_q;
  wire [DACC_PRESC_W-1:0] presc_d = presc_q + 1'b1;
  // staggered operation coarsens every base rate by eight
  wire [2:0] base_shift = staggered_mode ? DACC_STAGGER_SHIFT : 3'h0;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      presc_q <= DACC_PRESC_RST;
    end else begin
      presc_q <= presc_d;
    end
  end

  // ----------------------------------------------------------------
  // external count inputs: rising edge gives one count
  // ----------------------------------------------------------------
  logic [1:0] ext_cnt_prev_q;
  wire [1:0] ext_cnt_rise = ext_count_in & ~ext_cnt_prev_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ext_cnt_prev_q <= 2'b00;
    end else begin
      ext_cnt_prev_q <= ext_count_in;
    end
  end

  // ----------------------------------------------------------------
  // time bases: first_array_timer_a/_b, second_array_timer_a/_b
  // ----------------------------------------------------------------
  logic [15:0] tval_w [DACC_TIMERS];
  logic [DACC_TIMERS-1:0] tstep_w;
  logic [DACC_TIMERS-1:0] tovf_w;

  for (genvar t = 0; t < DACC_TIMERS; t++) begin : g_tmr
    wire [2:0] src = tmr_src[t*3 +: 3];
    wire [2:0] shift = base_shift + src;
    wire [DACC_PRESC_W-1:0] div_mask =
      DACC_PRESC_W'((8'd1 << shift) - 8'd1);
    wire presc_tick = (presc_q & div_mask) == '0;
    wire is_timer_a = (t % 2) == 0;
    logic step;
    wire wr_hit = tmr_wr_sel == DACC_TMR_IDX_W'(t);

    always_comb begin
      step = 1'b0;
      case (src)
        DACC_SRC_DIV1, DACC_SRC_DIV2, DACC_SRC_DIV4, DACC_SRC_DIV8: begin
          step = presc_tick;
        end
        DACC_SRC_EXT_OVF: begin
          step = ext_overflow_pulse;
        end
        DACC_SRC_EXT_CNT: begin
          step = is_timer_a & ext_cnt_rise[t/2];
        end
        default: begin
          step = 1'b0;
        end
      endcase
    end

    dacc_timer #(
      .WIDTH(DACC_W)
    ) u_tmr (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .step_en(step & tmr_run[t]),
      .wr_count(tmr_wr_count & wr_hit),
      .wr_reload(tmr_wr_reload & wr_hit),
      .wdata(tmr_wdata),
      .value_q(tval_w[t]),
      .step_q(tstep_w[t]),
      .ovf_q(tovf_w[t])
    );

    assign tmr_value_q[t*16 +: 16] = tval_w[t];
  end

  // ----------------------------------------------------------------
  // capture/compare registers
  // ----------------------------------------------------------------
  logic [15:0] ccval_q [DACC_CH];
  logic [DACC_CH-1:0] match_w;
  logic [DACC_CH-1:0] pin_prev_q;
  logic [DACC_CH-1:0] once_done_q;
  logic [DACC_CH-1:0] single_done_q;

  for (genvar c = 0; c < DACC_CH; c++) begin : g_ch
    localparam int unsigned ARR = c / DACC_REGS_PER_ARRAY;
    localparam int unsigned IDX = c % DACC_REGS_PER_ARRAY;
    localparam bit HAS_PIN = (ARR == 0) || (IDX < SECOND_PIN_REGS);
    localparam bit LOWER = IDX < DACC_DBL_PAIR_OFS;
    localparam int unsigned PARTNER =
      LOWER ? c + DACC_DBL_PAIR_OFS : c - DACC_DBL_PAIR_OFS;

    wire [2:0] func = cc_func[c*3 +: 3];
    wire is_cmp = func[2];
    wire is_cap = func == DACC_FN_CAPTURE;
    wire [1:0] cmode = func[1:0];
    // each register picks timer a or b of its own array
    wire [1:0] tsel = 2'(ARR * 2) + {1'b0, cc_timer_b_sel[c]};
    wire [15:0] tval = tval_w[tsel];
    wire tstep = tstep_w[tsel];
    wire tovf = tovf_w[tsel];

    // modes 2 and 3 act once per period
    wire once_mode = is_cmp & cmode[1];
    wire blocked = (once_mode & once_done_q[c]) |
                   (cc_single_event[c] & single_done_q[c]);
    // compare on every count of the timer
    wire raw_match = is_cmp & tstep & (tval == ccval_q[c]);
    assign match_w[c] = raw_match & ~blocked;

    // double register: lower pin toggles on partner match too
    wire dbl_on = LOWER ? cc_double_reg[c] : cc_double_reg[PARTNER];
    wire dbl_hit = LOWER & cc_double_reg[c] & match_w[PARTNER];
    // upper partner of a pair gives up its own pin
    wire pin_yield = ~LOWER & dbl_on;

    // capture edge detect; pins are synchronous to sys_clk
    wire pin_in = HAS_PIN ? cc_pin_in[c] : 1'b0;
    wire rise = pin_in & ~pin_prev_q[c];
    wire fall = ~pin_in & pin_prev_q[c];
    wire cap_hit = is_cap & HAS_PIN &
                   ((rise & cc_edge_sel[c*2 + DACC_EDGE_RISE_BIT]) |
                    (fall & cc_edge_sel[c*2 + DACC_EDGE_FALL_BIT]));

    logic pin_d;
    wire drives = HAS_PIN & ~pin_yield &
                  ((is_cmp & cmode[0]) | (LOWER & cc_double_reg[c]));

    always_comb begin
      pin_d = cc_pin_out_q[c];
      if (dbl_hit) begin
        pin_d = ~pin_d;
      end
      if (is_cmp & ~pin_yield) begin
        case (func)
          DACC_FN_CMP1: begin
            if (match_w[c]) begin
              pin_d = ~cc_pin_out_q[c] ^ dbl_hit;
            end
          end
          DACC_FN_CMP3: begin
            if (match_w[c]) begin
              pin_d = 1'b1;
            end else if (tovf) begin
              pin_d = 1'b0;
            end
          end
          default: begin
            pin_d = pin_d;
          end
        endcase
      end
      if (!HAS_PIN) begin
        pin_d = 1'b0;
      end
    end

    wire sw_wr = reg_wr & (reg_sel == DACC_CH_IDX_W'(c));
    wire [15:0] ccval_d = cap_hit ? tval :
                          sw_wr ? reg_wdata : ccval_q[c];
    // a new match outranks the period-end clear
    wire once_d = match_w[c] | (once_done_q[c] & ~tovf);
    wire single_d = (match_w[c] & cc_single_event[c]) |
                    (single_done_q[c] & ~sw_wr);

    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        ccval_q[c] <= DACC_RST_VAL;
        pin_prev_q[c] <= 1'b0;
        once_done_q[c] <= 1'b0;
        single_done_q[c] <= 1'b0;
        cc_pin_out_q[c] <= 1'b0;
        cc_pin_oe_b_q[c] <= 1'b1;
        cc_irq_q[c] <= 1'b0;
      end else begin
        ccval_q[c] <= ccval_d;
        pin_prev_q[c] <= pin_in;
        once_done_q[c] <= once_d;
        single_done_q[c] <= single_d;
        cc_pin_out_q[c] <= pin_d;
        cc_pin_oe_b_q[c] <= ~drives;
        cc_irq_q[c] <= match_w[c] | cap_hit;
      end
    end

    assign cc_single_done_q[c] = single_done_q[c];
  end

  // ----------------------------------------------------------------
  // read-back of the selected register
  // ----------------------------------------------------------------
  wire [15:0] rdata_d = ccval_q[reg_sel];

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_rdata_q <= DACC_RST_VAL;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

endmodule // dacc_top

// [dacc_props.sv]
// port assertions for the capture/compare top
module dacc_props (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic staggered_mode,
  input wire logic [11:0] tmr_src,
  input wire logic [3:0] tmr_run,
  input wire logic [1:0] tmr_wr_sel,
  input wire logic tmr_wr_count,
  input wire logic [95:0] cc_func,
  input wire logic [63:0] cc_edge_sel,
  input wire logic [31:0] cc_double_reg,
  input wire logic [31:0] cc_pin_in,
  input wire logic [31:0] cc_pin_out_q,
  input wire logic [31:0] cc_pin_oe_b_q,
  input wire logic [31:0] cc_irq_q,
  input wire logic [63:0] tmr_value_q
);
  timeunit 1ns;
  timeprecision 1ps;
  import dacc_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire logic [15:0] tv0 = tmr_value_q[15:0];
  wire logic wr0 = tmr_wr_count && tmr_wr_sel == 2'h0;
  wire logic cap0 = cc_func[2:0] == DACC_FN_CAPTURE;
  AST_NO_PIN: assert property (cc_pin_oe_b_q[31:28] == 4'hf)
    else $error("pinless channel drives");
  AST_TMR_HOLD: assert property (!tmr_run[0] && !wr0 |=>
    tv0 == $past(tv0)) else $error("stopped timer moved");
  AST_TMR_STEP: assert property (tmr_run[0] && !wr0 &&
    tmr_src[2:0] == 3'h0 && !staggered_mode && tv0 != 16'hffff
    |=> tv0 == $past(tv0) + 16'h1) else $error("timer missed a step");
  AST_CAP_RISE: assert property (cap0 && cc_edge_sel[0] &&
    $rose(cc_pin_in[0]) && $past(rst_b) |=> cc_irq_q[0])
    else $error("capture gave no interrupt");
  AST_CAP_FALL_OFF: assert property (cap0 &&
    cc_edge_sel[1:0] == 2'h1 && $fell(cc_pin_in[0]) && $past(rst_b)
    |=> !cc_irq_q[0]) else $error("falling edge captured");
  AST_OE_CAP: assert property (cap0 && !cc_double_reg[0] |=>
    cc_pin_oe_b_q[0]) else $error("capture pin driven");
  AST_OE_TOGGLE: assert property (cc_func[5:3] == DACC_FN_CMP1
    |=> !cc_pin_oe_b_q[1]) else $error("toggle pin not driven");
  AST_MODE0_PIN: assert property (cc_func[5:3] == DACC_FN_CMP0 &&
    $past(cc_func[5:3]) == DACC_FN_CMP0 && !cc_double_reg[1]
    |=> $stable(cc_pin_out_q[1])) else $error("mode 0 moved pin");
  AST_OFF_QUIET: assert property (cc_func[2:0] == DACC_FN_OFF &&
    $past(cc_func[2:0]) == DACC_FN_OFF |=> !cc_irq_q[0])
    else $error("idle channel interrupt");
endmodule // dacc_props

// [dacc_far.sv]
// far side: pin levels, external timer events, irq and edge counts
module dacc_far (
  input wire logic sys_clk,
  input wire logic [31:0] cc_pin_out_q,
  input wire logic [31:0] cc_pin_oe_b_q,
  input wire logic [31:0] cc_irq_q,
  output logic [31:0] cc_pin_in,
  output logic ext_overflow_pulse = 1'b0,
  output logic [1:0] ext_count_in = 2'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] lvl = 32'h0000_0000;
  logic last_pin = 1'b0;
  int irq_n = 0;
  int edge_n = 0;
  // a driven pin reads back its own level
  assign cc_pin_in = (~cc_pin_oe_b_q & cc_pin_out_q) | (cc_pin_oe_b_q & lvl);
  always @(posedge sys_clk) begin
    irq_n <= irq_n + int'(cc_irq_q[0] | cc_irq_q[1]);
    edge_n <= edge_n + int'(cc_pin_out_q[1] != last_pin);
    last_pin <= cc_pin_out_q[1];
  end
  // each round: one overflow pulse and one count rise on both inputs
  task automatic events(input int n);
    repeat (n) begin
      @(posedge sys_clk) ext_overflow_pulse <= 1'b1;
      ext_count_in <= 2'h3;
      @(posedge sys_clk) ext_overflow_pulse <= 1'b0;
      @(posedge sys_clk) ext_count_in <= 2'h0;
      @(posedge sys_clk);
    end
  endtask
  task automatic set_pin(input int i, input logic v);
    @(posedge sys_clk) lvl[i] <= v;
  endtask
endmodule // dacc_far

// [tb_top.sv]
// self-checking bench for the capture/compare top
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dacc_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, staggered_mode = 1'b0;
  logic ext_overflow_pulse, tmr_wr_count = 1'b0, tmr_wr_reload = 1'b0;
  logic reg_wr = 1'b0;
  logic [1:0] ext_count_in, tmr_wr_sel = 2'h0;
  logic [3:0] tmr_run = 4'h0;
  logic [4:0] reg_sel = 5'h00;
  logic [11:0] tmr_src = 12'h000;
  logic [15:0] tmr_wdata = 16'h0000, reg_wdata = 16'h0000, reg_rdata_q;
  logic [95:0] cc_func = '0;
  logic [63:0] cc_edge_sel = '0, tmr_value_q;
  logic [31:0] cc_timer_b_sel = '0, cc_single_event = '0;
  logic [31:0] cc_double_reg = '0, cc_pin_in, cc_pin_out_q;
  logic [31:0] cc_pin_oe_b_q, cc_irq_q, cc_single_done_q, seed = 74138;
  int err_count = 0, samples_checked = 0;
  dacc_fn_t fn_tab [6] = '{DACC_FN_CMP0, DACC_FN_CMP1, DACC_FN_CMP2,
    DACC_FN_CMP3, DACC_FN_CMP0, DACC_FN_CMP1};
  int xirq [6] = '{4, -1, 4, -1, 1, -1};
  int xedge [6] = '{0, 4, 0, 8, 0, 8};
  always #5 sys_clk = ~sys_clk;
  dacc_top dut (.*);
  dacc_far far (.*);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // count write when cnt, reload write otherwise
  task automatic twr(input logic [1:0] s, input logic cnt, input logic [15:0] d);
    @(posedge sys_clk) tmr_wr_sel <= s;
    tmr_wr_count <= cnt;
    tmr_wr_reload <= ~cnt;
    tmr_wdata <= d;
    @(posedge sys_clk) tmr_wr_count <= 1'b0;
    tmr_wr_reload <= 1'b0;
  endtask
  task automatic rwr(input logic [4:0] s, input logic [15:0] d);
    @(posedge sys_clk) reg_wr <= 1'b1;
    reg_sel <= s;
    reg_wdata <= d;
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    int n0, e0, n;
    logic [31:0] r;
    tick(2);
    rst_b <= 1'b1;
    tick(1);
    check(cc_pin_oe_b_q, 32'hffff_ffff);
    check(tmr_value_q[31:0] | cc_pin_out_q, 32'h0000_0000);
    // 64 cycles hold a whole number of every prescaler period
    for (int s = 0; s < 5; s++) begin
      staggered_mode <= (s == 4);
      tmr_src[5:3] <= (s == 4) ? 3'h0 : 3'(s);
      twr(2'h1, 1'b1, 16'h0000);
      tmr_run[1] <= 1'b1;
      tick(64);
      tmr_run[1] <= 1'b0;
      tick(2);
      check(tmr_value_q[31:16], (s == 4) ? 8 : 64 >> s);
    end
    staggered_mode <= 1'b0;
    r = xs();
    twr(2'h0, 1'b0, r[15:0]);
    twr(2'h0, 1'b1, 16'hfffe);
    tmr_run[0] <= 1'b1;
    tick(3);
    tmr_run[0] <= 1'b0;
    tick(2);
    check(tmr_value_q[15:0], r[15:0] + 16'h1);
    $display("timer tests done");
    tmr_src <= 12'h945;
    twr(2'h0, 1'b1, 16'h0000);
    tmr_run <= 4'hd;
    n = int'(xs() % 7) + 1;
    far.events(n);
    tick(4);
    tmr_run <= 4'h0;
    tick(2);
    check(tmr_value_q[63:48], n);
    check(tmr_value_q[15:0], n);
    check(tmr_value_q[47:32], n);
    $display("external source test done");
    tmr_src <= 12'h000;
    cc_func[2:0] <= DACC_FN_CAPTURE;
    for (int e = 1; e < 4; e++) begin
      r = xs();
      twr(2'h0, 1'b1, r[15:0]);
      cc_edge_sel[1:0] <= 2'(e);
      n0 = far.irq_n;
      far.set_pin(0, 1'b1);
      tick(3);
      far.set_pin(0, 1'b0);
      tick(3);
      check(far.irq_n - n0, (e == 3) ? 2 : 1);
      reg_sel <= 5'h00;
      tick(2);
      check(reg_rdata_q, r[15:0]);
    end
    cc_func[2:0] <= DACC_FN_OFF;
    $display("capture test done");
    cc_func[29:27] <= DACC_FN_CMP0;
    twr(2'h0, 1'b0, 16'hfff0);
    for (int m = 0; m < 6; m++) begin
      cc_func[5:3] <= fn_tab[m];
      cc_single_event[1] <= (m == 4);
      cc_double_reg[1] <= (m == 5);
      rwr(5'h01, 16'hfff4);
      rwr(5'h09, 16'hfff8);
      twr(2'h0, 1'b1, 16'hfff0);
      n0 = far.irq_n;
      e0 = far.edge_n;
      tmr_run[0] <= 1'b1;
      tick(64);
      tmr_run[0] <= 1'b0;
      tick(4);
      if (xirq[m] >= 0) check(far.irq_n - n0, xirq[m]);
      check(far.edge_n - e0, xedge[m]);
      if (m == 4) check(cc_single_done_q[1], 1'b1);
      if (m == 5) check(cc_pin_oe_b_q[9], 1'b1);
      $display("compare case %0d done", m);
    end
    finish_test();
  end
  initial begin
    tick(20000);
    err_count++;
    finish_test();
  end
endmodule // tb_top
bind dacc_top dacc_props u_props (.sys_clk(sys_clk), .rst_b(rst_b),
  .staggered_mode(staggered_mode), .tmr_src(tmr_src), .tmr_run(tmr_run),
  .tmr_wr_sel(tmr_wr_sel), .tmr_wr_count(tmr_wr_count), .cc_func(cc_func),
  .cc_edge_sel(cc_edge_sel), .cc_double_reg(cc_double_reg),
  .cc_pin_in(cc_pin_in), .cc_pin_out_q(cc_pin_out_q),
  .cc_pin_oe_b_q(cc_pin_oe_b_q), .cc_irq_q(cc_irq_q),
  .tmr_value_q(tmr_value_q));
